// File: mhsp_top.sv
`timescale 1ns/1ns
`include "mhsp_params.svh"
module mhsp_top (
  input wire logic core_clk_i,
  input wire logic link_clk_i,
  input wire logic reset_i,
  input wire logic iface_select_strap_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic spi_select_n_i,
  input wire logic addr_strap_bit_one_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic meas_done_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [6:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_we_o,
  output logic reg_re_o,
  output logic result_ready_out_o
);
  mhsp_pkg::mhsp_pins_s pins_raw;
  mhsp_pkg::mhsp_pins_s pins;
  mhsp_pkg::mhsp_pins_s pins_d;
  mhsp_pkg::mhsp_req_s req;
  mhsp_pkg::mhsp_req_s go_req;
  mhsp_pkg::mhsp_i2c_e st;
  logic sclk_rise;
  logic sclk_fall;
  logic [2:0] strap_cnt;
  logic strap_done;
  logic i2c_mode;
  logic [1:0] addr_lsbs;
  logic spi_mode;
  logic i2c_on;
  logic spi_act;
  logic sel_fall;
  logic [2:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] rx_byte;
  logic [7:0] tx_shift;
  logic shift_rise;
  logic bit_clr;
  logic spi_byte;
  logic spi_first;
  logic spi_rd;
  logic i2c_start;
  logic i2c_stop;
  logic i2c_full;
  logic i2c_rw;
  logic i2c_nack;
  logic reg_phase;
  logic dev_match;
  logic [6:0] reg_ptr;
  logic go;
  logic ptr_load;
  logic [6:0] ptr_val;
  logic req_tgl;
  logic [1:0] back_l;
  logic ack_seen;
  logic ack_evt;
  logic ready_l;
  logic req_tgl_c;
  logic req_seen;
  logic req_evt;
  logic ack_tgl;
  logic [7:0] rsp_data;
  logic res_hit;

  // link side: pins pass four flops before any edge is looked at
  assign pins_raw = {iface_select_strap_i, addr_strap_bit_one_i, spi_select_n_i, sdi_i, sclk_i};

  mhsp_sync #(.W(5), .INIT(`MHSP_PIN_INIT)) u_pin_sync ( // see R21
    .clk_i(link_clk_i),
    .reset_i(reset_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  mhsp_sync #(.W(2)) u_back_sync (
    .clk_i(link_clk_i),
    .reset_i(reset_i),
    .d_i({ack_tgl, result_ready_out_o}),
    .q_o(back_l)
  );

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pins_d <= `MHSP_PIN_INIT;
      ack_seen <= 1'b0;
    end else begin
      pins_d <= pins;
      ack_seen <= back_l[1];
    end
  end

  assign ready_l = back_l[0];
  assign ack_evt = back_l[1] != ack_seen;
  assign sclk_rise = pins.sclk && !pins_d.sclk; // see R21
  assign sclk_fall = !pins.sclk && pins_d.sclk;

  // straps are caught once after reset, when the synchronisers have settled;
  // the pin synchroniser still shows its reset value for three edges
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_cnt <= 3'h0;
      strap_done <= 1'b0;
      i2c_mode <= 1'b0;
      addr_lsbs <= 2'h0;
    end else if (strap_cnt != `MHSP_STRAP_WAIT) begin
      strap_cnt <= strap_cnt + 3'h1;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      i2c_mode <= pins.iface; // see R1
      addr_lsbs <= {pins.strap1, pins.sel_n}; // see R15
    end
  end

  assign spi_mode = strap_done && !i2c_mode; // see R1
  assign i2c_on = strap_done && i2c_mode;
  assign spi_act = spi_mode && !pins.sel_n;
  assign sel_fall = spi_mode && pins_d.sel_n && !pins.sel_n;
  assign i2c_start = i2c_on && pins.sclk && pins_d.sclk && pins_d.sdi && !pins.sdi;
  assign i2c_stop = i2c_on && pins.sclk && pins_d.sclk && !pins_d.sdi && pins.sdi;
  assign dev_match = rx_shift[7:1] == {`MHSP_I2C_ADDR_HI, addr_lsbs}; // see R15

  assign shift_rise = sclk_rise && (spi_act || (i2c_on && (st == mhsp_pkg::I2C_DEV
    || st == mhsp_pkg::I2C_RX || st == mhsp_pkg::I2C_TX)));
  assign bit_clr = (spi_mode && pins.sel_n) || i2c_start || (i2c_on && (st == mhsp_pkg::I2C_IDLE
    || st == mhsp_pkg::I2C_DACK || st == mhsp_pkg::I2C_RACK));
  assign rx_byte = {rx_shift[6:0], pins.sdi};
  assign spi_byte = spi_act && sclk_rise && bit_cnt == 3'h7;

  // one shifter serves both framings since they share the pins
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
    end else begin
      if (bit_clr) begin
        bit_cnt <= 3'h0; // see R19
      end else if (shift_rise) begin
        bit_cnt <= bit_cnt + 3'h1; // see R8
      end
      if (shift_rise) begin
        rx_shift <= rx_byte; // see R6 R14
      end
    end
  end

  // output byte: status on select, read data on answer, shift on falls
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_shift <= 8'h00;
    end else if (sel_fall) begin
      tx_shift <= {ready_l, 7'h00}; // see R4 R5 R18
    end else if (ack_evt && !req.we) begin
      tx_shift <= rsp_data;
    end else if (sclk_fall && bit_cnt != 3'h0
      && (spi_act || (i2c_on && st == mhsp_pkg::I2C_TX))) begin
      tx_shift <= {tx_shift[6:0], 1'b0}; // see R10
    end
  end

  assign miso_o = tx_shift[7];
  assign miso_oe_o = spi_act; // see R11 R13
  assign sda_o = 1'b0;
  assign sda_oe_o = i2c_on && (st == mhsp_pkg::I2C_DACK
    || (st == mhsp_pkg::I2C_TX && !tx_shift[7])); // see R14

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      spi_first <= 1'b1;
      spi_rd <= 1'b0;
    end else if (!spi_act) begin
      spi_first <= 1'b1; // see R19
      spi_rd <= 1'b0;
    end else if (spi_byte) begin
      spi_first <= 1'b0;
      if (spi_first) begin
        spi_rd <= rx_byte[7]; // see R18
      end
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= mhsp_pkg::I2C_IDLE;
      i2c_full <= 1'b0;
      i2c_rw <= 1'b0;
      i2c_nack <= 1'b0;
      reg_phase <= 1'b0;
    end else if (!i2c_on || i2c_stop) begin
      st <= mhsp_pkg::I2C_IDLE;
      i2c_full <= 1'b0;
    end else if (i2c_start) begin
      st <= mhsp_pkg::I2C_DEV;
      i2c_full <= 1'b0;
    end else begin
      if (shift_rise && bit_cnt == 3'h7) begin
        i2c_full <= 1'b1;
      end
      case (st)
        mhsp_pkg::I2C_DEV: begin
          if (sclk_fall && i2c_full) begin
            i2c_full <= 1'b0;
            if (dev_match) begin
              st <= mhsp_pkg::I2C_DACK;
              i2c_rw <= rx_shift[0];
              reg_phase <= !rx_shift[0];
            end else begin
              st <= mhsp_pkg::I2C_IDLE;
            end
          end
        end
        mhsp_pkg::I2C_DACK: begin
          if (sclk_fall) begin
            st <= i2c_rw ? mhsp_pkg::I2C_TX : mhsp_pkg::I2C_RX;
          end
        end
        mhsp_pkg::I2C_RX: begin
          if (sclk_fall && i2c_full) begin
            i2c_full <= 1'b0;
            reg_phase <= 1'b0;
            st <= mhsp_pkg::I2C_DACK;
          end
        end
        mhsp_pkg::I2C_TX: begin
          if (sclk_fall && i2c_full) begin
            i2c_full <= 1'b0;
            st <= mhsp_pkg::I2C_RACK;
          end
        end
        mhsp_pkg::I2C_RACK: begin
          if (sclk_rise) begin
            i2c_nack <= pins.sdi;
          end
          if (sclk_fall) begin
            st <= i2c_nack ? mhsp_pkg::I2C_IDLE : mhsp_pkg::I2C_TX;
          end
        end
        default: st <= mhsp_pkg::I2C_IDLE;
      endcase
    end
  end

  // reads are fetched one byte ahead, so a burst may read one extra register
  always_comb begin
    go = 1'b0;
    go_req = '0;
    go_req.addr = reg_ptr;
    ptr_load = 1'b0;
    ptr_val = rx_byte[6:0];
    if (spi_byte) begin
      if (spi_first) begin
        go = rx_byte[7];
        go_req.addr = rx_byte[6:0];
        ptr_load = !rx_byte[7];
      end else begin
        go = 1'b1;
        go_req.we = !spi_rd;
        go_req.wdata = rx_byte;
      end
    end else if (i2c_on && sclk_fall && i2c_full) begin
      if (st == mhsp_pkg::I2C_DEV) begin
        go = dev_match && rx_shift[0];
      end else if (st == mhsp_pkg::I2C_RX) begin
        go = !reg_phase;
        go_req.we = 1'b1;
        go_req.wdata = rx_shift;
        ptr_load = reg_phase;
        ptr_val = rx_shift[6:0];
      end
    end else if (i2c_on && st == mhsp_pkg::I2C_RACK && sclk_rise && !pins.sdi) begin
      go = 1'b1;
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_ptr <= 7'h00;
    end else if (ptr_load) begin
      reg_ptr <= ptr_val;
    end else if (go) begin
      reg_ptr <= go_req.addr + 7'h1; // see R18 R20
    end
  end

  // request words stay still while the toggle crosses over
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      req <= '0;
      req_tgl <= 1'b0;
    end else if (go) begin
      req <= go_req;
      req_tgl <= ~req_tgl;
    end
  end

  // core side
  mhsp_sync #(.W(1)) u_req_sync (
    .clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i(req_tgl),
    .q_o(req_tgl_c)
  );

  assign req_evt = req_tgl_c != req_seen;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_seen <= 1'b0;
      reg_we_o <= 1'b0;
      reg_re_o <= 1'b0;
      reg_addr_o <= 7'h00;
      reg_wdata_o <= 8'h00;
    end else begin
      req_seen <= req_tgl_c;
      reg_we_o <= req_evt && req.we;
      reg_re_o <= req_evt && !req.we;
      if (req_evt) begin
        reg_addr_o <= req.addr;
        reg_wdata_o <= req.wdata;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_tgl <= 1'b0;
      rsp_data <= 8'h00;
    end else if (reg_we_o || reg_re_o) begin
      ack_tgl <= ~ack_tgl;
      if (reg_re_o) begin
        rsp_data <= reg_rdata_i;
      end
    end
  end

  assign res_hit = reg_re_o && reg_addr_o >= `MHSP_RESULT_FIRST
    && reg_addr_o <= `MHSP_RESULT_LAST;

  // a completion in the same cycle as a clearing access keeps the flag up
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      result_ready_out_o <= 1'b0;
    end else if (meas_done_i) begin
      result_ready_out_o <= 1'b1; // see R2
    end else if (reg_we_o || res_hit) begin
      result_ready_out_o <= 1'b0; // see R3
    end
  end

  sequence s_sel_fall;
    spi_mode && $fell(pins.sel_n);
  endsequence

  sequence s_last_bit;
    spi_act && sclk_rise && bit_cnt == 3'h7;
  endsequence

  chk_miso_released: assert property ( // see R11
    @(posedge link_clk_i) disable iff (reset_i) pins.sel_n |-> !miso_oe_o)
    else $error("spi output driven while deselected");
  chk_i2c_no_miso: assert property ( // see R1
    @(posedge link_clk_i) disable iff (reset_i) !spi_mode |-> !miso_oe_o)
    else $error("spi output driven outside spi mode");
  chk_status_first: assert property ( // see R5
    @(posedge link_clk_i) disable iff (reset_i)
    s_sel_fall |=> miso_oe_o && miso_o == $past(ready_l))
    else $error("status bit not shown on select");
  chk_byte_wrap: assert property ( // see R8
    @(posedge link_clk_i) disable iff (reset_i) s_last_bit |=> bit_cnt == 3'h0)
    else $error("byte not closed after eight bits");
  chk_msb_first: assert property ( // see R6
    @(posedge link_clk_i) disable iff (reset_i)
    shift_rise |=> rx_shift[0] == $past(pins.sdi) && rx_shift[7:1] == $past(rx_shift[6:0]))
    else $error("input bit not shifted in on rise");
  chk_spi_abort: assert property ( // see R19
    @(posedge link_clk_i) disable iff (reset_i)
    spi_mode && $rose(pins.sel_n) |=> bit_cnt == 3'h0 && spi_first && !spi_rd)
    else $error("transfer not aborted on deselect");
  chk_i2c_inc: assert property ( // see R20
    @(posedge link_clk_i) disable iff (reset_i)
    i2c_on && st == mhsp_pkg::I2C_RX && sclk_fall && i2c_full && !reg_phase
    |=> reg_ptr == $past(reg_ptr) + 7'h1 ##1 $changed(req_tgl) == 1'b0)
    else $error("i2c write address not incremented");
  chk_ready_set: assert property ( // see R2
    @(posedge core_clk_i) disable iff (reset_i) meas_done_i |=> result_ready_out_o)
    else $error("ready not raised on completion");
  chk_ready_clear: assert property ( // see R3
    @(posedge core_clk_i) disable iff (reset_i)
    (reg_we_o || res_hit) && !meas_done_i |=> !result_ready_out_o)
    else $error("ready not dropped on access");
endmodule

// File: mhsp_params.svh
`ifndef MHSP_PARAMS_SVH
`define MHSP_PARAMS_SVH
// Function
// R1 - strap high picks i2c, low picks spi
// R2 - raise ready output when measurement completes
// R3 - drop ready on result read or write
// R4 - ready also shown in status byte
// R5 - mode three shows ready on output early
// R6 - spi input msb first, rising edge
// R7 - master changes input on falling edges
// R8 - eight serial clocks per byte
// R9 - master keeps spi clock within limit
// R10 - spi output msb first for master
// R11 - spi output released while deselected
// R12 - master selects before and throughout access
// R13 - device keeps working while deselected
// R14 - i2c uses one data line, msb first
// R15 - i2c address from fixed bits plus straps
// R16 - master keeps i2c clock within limit
// R17 - i2c master changes data on falls
// R18 - command byte, status back, address increments
// R19 - deselect aborts spi transfer at once
// R20 - i2c write increments address per byte
// R21 - sync pins, detect edges before shifting
`define MHSP_I2C_ADDR_HI 5'h08
`define MHSP_RESULT_FIRST 7'h24
`define MHSP_RESULT_LAST 7'h2c
`define MHSP_STRAP_WAIT 3'h6
`define MHSP_PIN_INIT 5'h07
`endif

// File: mhsp_pkg.sv
package mhsp_pkg;
  typedef struct packed {
    logic iface;
    logic strap1;
    logic sel_n;
    logic sdi;
    logic sclk;
  } mhsp_pins_s;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } mhsp_req_s;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_DEV = 3'h1,
    I2C_DACK = 3'h3,
    I2C_RX = 3'h2,
    I2C_TX = 3'h6,
    I2C_RACK = 3'h7
  } mhsp_i2c_e;
endpackage

// File: mhsp_sync.sv
`timescale 1ns/1ns
module mhsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // a bit only moves once stages two and three agree
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q_o <= INIT;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q_o <= (s2 & s3) | (q_o & (s2 ^ s3));
    end
  end
endmodule

// File: mhsp_host.sv
`timescale 1ns/1ns
module mhsp_host #(
  parameter int H = 42
) (
  input wire logic link_clk_i,
  input wire logic miso_i,
  input wire logic miso_oe_i,
  input wire logic sda_oe_i,
  output logic sclk_o,
  output logic sdi_o,
  output logic sel_n_o
);
  logic dq = 1'b1;
  logic last = 1'b0;
  logic miso_w;
  initial sclk_o = 1'b0;
  initial sel_n_o = 1'b1;
  // pull-up: the wire is low only when someone pulls it
  assign sdi_o = dq & ~sda_oe_i;
  // a released output shows the inverse of its last bit, never a kind guess
  assign miso_w = miso_oe_i ? miso_i : ~last;
  always @(posedge link_clk_i) begin
    if (miso_oe_i) begin
      last <= miso_i;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk_i);
  endtask
  // half period of 42 link cycles keeps the serial clock under 1 MHz
  // the idle clock level is set while deselected, so no edge lands with select
  task automatic spi_begin(input logic cpol);
    sclk_o <= cpol;
    tick(H);
    sel_n_o <= 1'b0;
    tick(H);
  endtask
  task automatic spi_byte(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i >= 8 - n; i--) begin
      sclk_o <= 1'b0;
      dq <= tx[i];
      tick(H);
      sclk_o <= 1'b1;
      rx[i] = miso_w;
      tick(H);
    end
  endtask
  task automatic spi_end(input logic cpol);
    if (!cpol) begin
      sclk_o <= 1'b0;
    end
    tick(H);
    sel_n_o <= 1'b1;
    tick(H);
  endtask
  // in i2c mode the select pin only carries an address strap
  task automatic set_sel_n(input logic v);
    sel_n_o <= v;
  endtask
  // a short pause after each fall keeps data moves clear of the high clock
  task automatic i2c_bit(input logic b, output logic r);
    dq <= b;
    tick(H);
    sclk_o <= 1'b1;
    tick(H);
    r = sdi_o;
    sclk_o <= 1'b0;
    tick(4);
  endtask
  task automatic i2c_byte(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                          output logic ack);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(tx[i], rx[i]);
    end
    i2c_bit(ai, ack);
  endtask
  task automatic i2c_start();
    dq <= 1'b1;
    tick(H);
    sclk_o <= 1'b1;
    tick(H);
    dq <= 1'b0;
    tick(H);
    sclk_o <= 1'b0;
    tick(4);
  endtask
  task automatic i2c_stop();
    dq <= 1'b0;
    tick(H);
    sclk_o <= 1'b1;
    tick(H);
    dq <= 1'b1;
    tick(H);
  endtask
endmodule

// File: mhsp_top_bench.sv
`timescale 1ns/1ns
module mhsp_top_bench;
  logic core_clk_i = 1'b0;
  logic link_clk_i = 1'b1;
  logic reset_i = 1'b1;
  logic strap = 1'b0;
  logic strap1 = 1'b0;
  logic meas_done = 1'b0;
  logic sclk, sdi, sel_n, miso, miso_oe, sda, sda_oe, reg_we, reg_re, rdy, pin28, ack;
  logic [6:0] reg_addr, rd_addr;
  logic [7:0] reg_wdata, reg_rdata, rx;
  logic [7:0] regs [128];
  int err_total = 0;
  int checks_done = 0;
  always #2 core_clk_i = ~core_clk_i;
  // link rising edges never meet core rising edges
  always #6 link_clk_i = ~link_clk_i;
  assign pin28 = miso_oe ? miso : strap1;
  assign reg_rdata = regs[reg_addr];
  always @(posedge core_clk_i) begin
    if (reg_we === 1'b1) begin
      regs[reg_addr] <= reg_wdata;
    end
    if (reg_re === 1'b1) begin
      rd_addr <= reg_addr;
    end
  end
  mhsp_top DUT (.core_clk_i(core_clk_i), .link_clk_i(link_clk_i), .reset_i(reset_i),
    .iface_select_strap_i(strap), .sclk_i(sclk), .sdi_i(sdi), .spi_select_n_i(sel_n),
    .addr_strap_bit_one_i(pin28), .miso_o(miso), .miso_oe_o(miso_oe), .sda_o(sda),
    .sda_oe_o(sda_oe), .meas_done_i(meas_done), .reg_rdata_i(reg_rdata),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_we_o(reg_we), .reg_re_o(reg_re),
    .result_ready_out_o(rdy));
  mhsp_host host (.link_clk_i(link_clk_i), .miso_i(miso), .miso_oe_i(miso_oe),
    .sda_oe_i(sda_oe), .sclk_o(sclk), .sdi_o(sdi), .sel_n_o(sel_n));
  function automatic logic [7:0] pat(input logic [6:0] a);
    return {a, 1'b0} ^ 8'h3c;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic pulse_meas();
    @(posedge core_clk_i);
    meas_done <= 1'b1;
    @(posedge core_clk_i);
    meas_done <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask
  task automatic t_spi_read();
    pulse_meas();
    chk(rdy, 8'h01, "ready after measurement");
    host.spi_begin(1'b1);
    chk(miso_oe, 8'h01, "output driven while selected");
    host.spi_byte(8'ha4, 8, rx);
    chk(rx, 8'h80, "status shows ready");
    host.spi_byte(8'h00, 8, rx);
    chk(rx, pat(7'h24), "first result byte");
    host.spi_byte(8'h00, 8, rx);
    chk(rx, pat(7'h25), "next result byte");
    chk(rdy, 8'h00, "ready after result read");
    host.spi_end(1'b1);
    chk(miso_oe, 8'h00, "output released");
    chk({1'b0, rd_addr}, 8'h26, "burst prefetch address");
    $display("test spi read done");
  endtask
  task automatic t_spi_write();
    pulse_meas();
    host.spi_begin(1'b0);
    host.spi_byte(8'h10, 8, rx);
    chk(rx, 8'h80, "status in mode 0");
    host.spi_byte(8'h5a, 8, rx);
    host.spi_byte(8'hc3, 8, rx);
    host.spi_end(1'b0);
    chk(regs[16], 8'h5a, "first written byte");
    chk(regs[17], 8'hc3, "second written byte");
    chk(rdy, 8'h00, "ready after write");
    $display("test spi write done");
  endtask
  task automatic t_spi_abort();
    host.spi_begin(1'b0);
    host.spi_byte(8'h20, 8, rx);
    host.spi_byte(8'hff, 4, rx);
    host.spi_end(1'b0);
    chk(regs[32], pat(7'h20), "aborted byte not written");
    pulse_meas();
    chk(rdy, 8'h01, "ready while deselected");
    host.spi_begin(1'b0);
    host.spi_byte(8'h20, 8, rx);
    host.spi_byte(8'h0f, 8, rx);
    host.spi_end(1'b0);
    chk(regs[32], 8'h0f, "write after abort aligned");
    $display("test spi abort done");
  endtask
  task automatic t_i2c();
    host.i2c_start();
    host.i2c_byte(8'h42, 1'b1, rx, ack);
    chk(ack, 8'h00, "own address acked");
    host.i2c_byte(8'h30, 1'b1, rx, ack);
    host.i2c_byte(8'h3c, 1'b1, rx, ack);
    chk(ack, 8'h00, "data acked");
    host.i2c_byte(8'hc3, 1'b1, rx, ack);
    host.i2c_stop();
    chk(regs[48], 8'h3c, "i2c first write");
    chk(regs[49], 8'hc3, "i2c next write");
    chk(miso_oe, 8'h00, "spi output idle");
    host.i2c_start();
    host.i2c_byte(8'h46, 1'b1, rx, ack);
    chk(ack, 8'h01, "other address ignored");
    host.i2c_stop();
    host.i2c_start();
    host.i2c_byte(8'h42, 1'b1, rx, ack);
    host.i2c_byte(8'h30, 1'b1, rx, ack);
    host.i2c_stop();
    host.i2c_start();
    host.i2c_byte(8'h43, 1'b1, rx, ack);
    chk(ack, 8'h00, "read address acked");
    host.i2c_byte(8'hff, 1'b0, rx, ack);
    chk(rx, 8'h3c, "i2c first read");
    host.i2c_byte(8'hff, 1'b1, rx, ack);
    chk(rx, 8'hc3, "i2c next read");
    host.i2c_stop();
    chk({1'b0, rd_addr}, 8'h31, "last i2c read address");
    $display("test i2c done");
  endtask
  task automatic t_i2c_straps();
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    strap1 <= 1'b1;
    host.set_sel_n(1'b0);
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (20) @(posedge link_clk_i);
    host.i2c_start();
    host.i2c_byte(8'h44, 1'b1, rx, ack);
    chk(ack, 8'h00, "strapped address acked");
    host.i2c_stop();
    host.i2c_start();
    host.i2c_byte(8'h42, 1'b1, rx, ack);
    chk(ack, 8'h01, "old address ignored");
    host.i2c_stop();
    chk(sda, 8'h00, "sda only pulls low");
    $display("test i2c straps done");
  endtask
  initial begin
    for (int i = 0; i < 128; i++) begin
      regs[i] = pat(i[6:0]);
    end
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (20) @(posedge link_clk_i);
    t_spi_read();
    t_spi_write();
    t_spi_abort();
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    strap <= 1'b1;
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (20) @(posedge link_clk_i);
    t_i2c();
    t_i2c_straps();
    end_sim();
  end
  // the run needs about 55000 core cycles
  initial begin
    repeat (80000) @(posedge core_clk_i);
    err_total++;
    end_sim();
  end
endmodule
